// File: logic/biw_top.v
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "biw_defs.vh"
module biw_top (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        clk_en,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [11:0] s_axi_araddr,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    input  wire [15:0] compat_irq,
    input  wire        rtc_irq_low,
    input  wire        nic_int_a,
    input  wire [3:0]  slot32_int,
    input  wire [3:0]  slot64a_int,
    input  wire [3:0]  slot64b_int,
    input  wire        serialized_irq_line_in,
    output wire        serialized_irq_line_out,
    output wire        serialized_irq_line_oe,
    input  wire        pci_other_err,
    input  wire        serr_in,
    input  wire        power_button_in_n,
    input  wire        reset_button,
    input  wire        nmi_button,
    input  wire        os_smi_req,
    input  wire        pme_in,
    input  wire        rtc_alarm,
    input  wire        mouse_wake,
    input  wire        kbd_wake,
    input  wire        usb_wake,
    input  wire [2:0]  sleep_state,
    output reg         cpu_intr,
    output reg         cpu_nmi,
    output reg         cpu_smi,
    output reg         sci_req,
    output reg         serr_out,
    output reg         hard_reset,
    output reg         wake_event,
    output reg         sleep_state3_out,
    output reg         apic_clk,
    input  wire [1:0]  apic_data_in,
    output reg  [1:0]  apic_data_out,
    output reg  [1:0]  apic_data_oe
);
    localparam S_S0 = 3'd0;
    localparam S_S1 = 3'd1;
    localparam S_S4 = 3'd4;
    localparam S_S5 = 3'd5;
    reg [31:0] ctrl_q;
    reg [7:0]  wake_en_q;
    reg        acpi_q;
    reg        off_q;
    reg        btn_q;
    reg [23:0] irq_prev_q;
    reg [31:0] msg_cnt_q;
    reg [5:0]  msg_bit_q;
    reg [31:0] msg_sr_q;
    reg [23:0] pend_q;
    reg [31:0] pci_stat_q;
    reg        aw_hold_q;
    reg        w_hold_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    wire [16:0] sirq_slots;
    wire        sirq_done;
    wire        btn = ~power_button_in_n;
    wire        btn_rise = btn & ~btn_q;
    // Board pin routing to hub and bridge inputs
    wire [7:0] hub_pci_irq; // A..H
    wire hub_pci_irq_in_c = nic_int_a;
    wire hub_pci_irq_in_f = slot32_int[0];
    wire hub_pci_irq_in_g = slot32_int[1];
    wire hub_pci_irq_in_e = slot32_int[2];
    wire hub_pci_irq_in_h = slot32_int[3];
    assign hub_pci_irq = {hub_pci_irq_in_h, hub_pci_irq_in_g, hub_pci_irq_in_f,
                          hub_pci_irq_in_e, 1'b0, hub_pci_irq_in_c, 2'b00};
    wire [7:0] bridge_irq;
    wire bridge_irq_in_0 = slot64a_int[0];
    wire bridge_irq_in_4 = slot64b_int[3];
    assign bridge_irq = {slot64b_int[2], slot64b_int[1], slot64b_int[0], bridge_irq_in_4,
                         slot64a_int[3], slot64a_int[2], slot64a_int[1],
                         bridge_irq_in_0};
    // Compatibility levels; serial slots OR in, RTC low inverted
    wire [15:0] compat_lvl;
    assign compat_lvl = (compat_irq | sirq_slots[15:0]) & 16'hFEFF
                        | {7'h00, ~rtc_irq_low, 8'h00};
    wire [15:0] compat_all = compat_lvl | {6'h00, sci_req, 9'h000};
    // Cascade: secondary group drives primary level 2
    wire sec_out = |compat_all[15:8];
    wire [7:0] prim_in = {compat_all[7:3], compat_all[2] | sec_out, compat_all[1:0]};
    // Sources 0-15 compat, 16-23 hub PCI; bridge folded onto hub inputs
    wire [23:0] all_src = {hub_pci_irq | bridge_irq, compat_all};
    wire [23:0] src_rise = all_src & ~irq_prev_q;
    wire [4:0] msg_vec;
    reg  [4:0] enc;
    integer    i;
    always @*
    begin
        enc = 5'h00;
        for (i = 23; i >= 0; i = i - 1)
            if (pend_q[i])
                enc = i[4:0];
    end
    assign msg_vec = enc;
    wire wake_any = btn_rise
        | (pme_in & (acpi_q ? (sleep_state == S_S1 || sleep_state == S_S4)
                            : (sleep_state == S_S5 && wake_en_q[0])))
        | (acpi_q & rtc_alarm & wake_en_q[1]
           & (sleep_state == S_S1 || sleep_state == S_S4))
        | (acpi_q & (mouse_wake | kbd_wake | usb_wake) & wake_en_q[2]
           & sleep_state == S_S1);
    wire aw_ok = aw_hold_q | s_axi_awvalid;
    wire w_ok  = w_hold_q | s_axi_wvalid;
    wire [11:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
    wire [3:0]  ws = w_hold_q ? wstrb_q : s_axi_wstrb;
    wire do_wr = aw_ok & w_ok & ~s_axi_bvalid & clk_en;
    assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid & clk_en;
    assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid & clk_en;
    assign s_axi_arready = ~s_axi_rvalid & clk_en;
    wire wr_ctrl = do_wr & (wa == `BIW_ADDR_CTRL);
    wire [31:0] ctrl_wd = {ws[3] ? wd[31:24] : ctrl_q[31:24], ws[2] ? wd[23:16] : ctrl_q[23:16],
                           ws[1] ? wd[15:8] : ctrl_q[15:8], ws[0] ? wd[7:0] : ctrl_q[7:0]};
    biw_sirq u_sirq (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .clk_en     (clk_en),
        .quiet_mode (ctrl_q[`BIW_CTRL_QUIET]),
        .line_in    (serialized_irq_line_in),
        .line_out   (serialized_irq_line_out),
        .line_oe    (serialized_irq_line_oe),
        .slot_irq_q (sirq_slots),
        .cycle_done (sirq_done)
    );
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= `BIW_CTRL_RESET;
            wake_en_q <= `BIW_WAKE_EN_RESET;
            acpi_q <= 1'b0;
            off_q <= 1'b0;
            btn_q <= 1'b0;
            irq_prev_q <= 24'h000000;
            pend_q <= 24'h000000;
            msg_cnt_q <= 32'h0000_0000;
            msg_bit_q <= 6'h00;
            msg_sr_q <= 32'h0000_0000;
            pci_stat_q <= 32'h0000_0000;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
            cpu_intr <= 1'b0;
            cpu_nmi <= 1'b0;
            cpu_smi <= 1'b0;
            sci_req <= 1'b0;
            serr_out <= 1'b0;
            hard_reset <= 1'b0;
            wake_event <= 1'b0;
            sleep_state3_out <= 1'b1;
            apic_clk <= 1'b0;
            apic_data_out <= 2'b11;
            apic_data_oe <= 2'b00;
        end
        else if (clk_en)
        begin
            btn_q <= btn;
            irq_prev_q <= all_src;
            // Write channel capture, either order
            if (s_axi_awvalid & s_axi_awready & ~(w_ok))
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready & ~(aw_ok))
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wa == `BIW_ADDR_CTRL || wa == `BIW_ADDR_WAKE_EN
                                || wa == `BIW_ADDR_PCI_STAT) ? 2'b00 : 2'b10;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_ctrl)
                ctrl_q <= ctrl_wd;
            if (do_wr && wa == `BIW_ADDR_WAKE_EN && ws[0])
                wake_en_q <= wd[7:0];
            // Firmware acks OS SMI to enter ACPI; only reset leaves it
            if (wr_ctrl && ctrl_wd[`BIW_CTRL_SMI_ACK] && cpu_smi)
                acpi_q <= 1'b1;
            // Error status: set wins over write-one-clear
            pci_stat_q[0] <= pci_other_err | serr_in
                | (pci_stat_q[0] & ~(do_wr && wa == `BIW_ADDR_PCI_STAT && wd[0]));
            serr_out <= pci_other_err | serr_in;
            cpu_nmi <= nmi_button
                | ((pci_other_err | serr_in) & ctrl_q[`BIW_CTRL_SERR_NMI]);
            hard_reset <= reset_button;
            // Power button: while off wakes; while on SMI or SCI per mode
            wake_event <= (off_q | (sleep_state != S_S0)) & wake_any;
            if ((off_q | sleep_state != S_S0) & wake_any)
            begin
                off_q <= 1'b0;
                sleep_state3_out <= 1'b0;
            end
            else if (wr_ctrl && ctrl_wd[`BIW_CTRL_OFF])
            begin
                off_q <= 1'b1;
                sleep_state3_out <= 1'b1;
            end
            if (btn_rise & ~off_q & sleep_state == S_S0 & ~acpi_q)
                cpu_smi <= 1'b1;
            else if (os_smi_req & ~acpi_q)
                cpu_smi <= 1'b1;
            else if (wr_ctrl && ctrl_wd[`BIW_CTRL_SMI_ACK])
                cpu_smi <= 1'b0;
            if (btn_rise & ~off_q & sleep_state == S_S0 & acpi_q)
                sci_req <= 1'b1;
            else if (wr_ctrl && ctrl_wd[`BIW_CTRL_SMI_ACK])
                sci_req <= 1'b0;
            // Legacy: single shared line from primary controller
            cpu_intr <= ~ctrl_q[`BIW_CTRL_APIC] & (|prim_in);
            // APIC: queue rising edges, shift one 32-bit message each
            pend_q <= (pend_q | (ctrl_q[`BIW_CTRL_APIC] ? src_rise : 24'h000000));
            apic_clk <= ~apic_clk;
            if (apic_clk)
            begin
                if (msg_bit_q != 6'h00)
                begin
                    apic_data_out <= msg_sr_q[1:0];
                    apic_data_oe <= 2'b11;
                    msg_sr_q <= {2'b00, msg_sr_q[31:2]};
                    msg_bit_q <= msg_bit_q - 6'h02;
                end
                else if (pend_q != 24'h000000)
                begin
                    msg_sr_q <= {24'h000000, 3'b000, msg_vec};
                    msg_bit_q <= `BIW_MSG_BITS;
                    pend_q[msg_vec] <= 1'b0;
                    msg_cnt_q <= msg_cnt_q + 32'h0000_0001;
                end
                else
                begin
                    apic_data_out <= 2'b11;
                    apic_data_oe <= 2'b00;
                end
            end
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `BIW_ADDR_CTRL: s_axi_rdata <= ctrl_q;
                    `BIW_ADDR_STATUS: s_axi_rdata <= {26'h0000000, sleep_state3_out, off_q,
                                                      sci_req, cpu_smi, cpu_intr, acpi_q};
                    `BIW_ADDR_WAKE_EN: s_axi_rdata <= {24'h000000, wake_en_q};
                    `BIW_ADDR_SERIALIZED_IRQ_LINE: s_axi_rdata <= {15'h0000, sirq_slots};
                    `BIW_ADDR_IRQ_STAT: s_axi_rdata <= {8'h00, all_src};
                    `BIW_ADDR_PCI_STAT: s_axi_rdata <= pci_stat_q;
                    `BIW_ADDR_MSG: s_axi_rdata <= msg_cnt_q;
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// File: logic/biw_defs.vh
// What this block does
// - Secondary levels 8-15 cascade into primary level 2
// - Legacy mode drives one shared interrupt line
// - NIC to hub C; slot32 A-D to F,G,E,H
// - First 64-bit slot A-D to bridge 0-3
// - APIC mode sends each pending source as one serial message; repeat edges before it is sent merge
// - Monitor PCI and sixteen compatibility interrupts, beyond sixteen
// - Default logical map timer 0 through IDE 15
// - RTC level 8 active low; control interrupt on 9
// - Serial cycle: start, 17 slots, stop
// - Continuous mode: host alone starts frames
// - Other errors on SERR; NMI only if enabled
// - ACPI entry via SMI response; resets return legacy
// - Button while off wakes, deasserts sleep-state-3 output
// - Legacy button while on raises SMI
// - ACPI button while on raises control interrupt
// - Reset button hard-resets; NMI button forces NMI
// - Button always wakes; PME per mode and state
// - RTC, mouse, keyboard, USB wake only under ACPI
`ifndef BIW_DEFS_VH
`define BIW_DEFS_VH
`define BIW_ADDR_CTRL      12'h000
`define BIW_ADDR_STATUS    12'h004
`define BIW_ADDR_WAKE_EN   12'h008
`define BIW_ADDR_SERIALIZED_IRQ_LINE    12'h00C
`define BIW_ADDR_IRQ_STAT  12'h010
`define BIW_ADDR_PCI_STAT  12'h014
`define BIW_ADDR_MSG       12'h018
`define BIW_CTRL_ACPI      0
`define BIW_CTRL_APIC      1
`define BIW_CTRL_SERR_NMI  2
`define BIW_CTRL_QUIET     3
`define BIW_CTRL_SMI_ACK   4
`define BIW_CTRL_OFF       5
`define BIW_CTRL_RESET     32'h0000_0000
`define BIW_WAKE_EN_RESET  8'h00
`define BIW_SIRQ_SLOTS     8'd17
`define BIW_SIRQ_START_CLKS 4'd4
`define BIW_SIRQ_STOP_CLKS  4'd2
`define BIW_MSG_BITS       6'd32
`endif

// File: logic/biw_sirq.v
`timescale 1ns/1ps
`include "biw_defs.vh"
module biw_sirq (
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        clk_en,
    input  wire        quiet_mode,
    input  wire        line_in,
    output reg         line_out,
    output reg         line_oe,
    output reg  [16:0] slot_irq_q,
    output reg         cycle_done
);
    localparam IDLE = 2'd0;
    localparam START = 2'd1;
    localparam SLOTS = 2'd2;
    localparam STOP = 2'd3;
    reg [1:0] state_q;
    reg [3:0] cnt_q;
    reg [4:0] slot_q;
    reg [1:0] phase_q;
    reg [16:0] acc_q;
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q    <= IDLE;
            cnt_q      <= 4'h0;
            slot_q     <= 5'h00;
            phase_q    <= 2'h0;
            acc_q      <= 17'h00000;
            slot_irq_q <= 17'h00000;
            line_out   <= 1'b1;
            line_oe    <= 1'b0;
            cycle_done <= 1'b0;
        end
        else if (clk_en)
        begin
            cycle_done <= 1'b0;
            case (state_q)
                IDLE:
                begin
                    line_oe <= 1'b0;
                    cnt_q   <= 4'h0;
                    // Host starts in continuous mode; slave low start in quiet mode
                    if (!quiet_mode)
                    begin
                        state_q  <= START;
                        line_out <= 1'b0;
                        line_oe  <= 1'b1;
                    end
                    else if (!line_in)
                    begin
                        state_q  <= START;
                        line_out <= 1'b0;
                        line_oe  <= 1'b1;
                        cnt_q    <= 4'h1;
                    end
                end
                START:
                begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `BIW_SIRQ_START_CLKS - 4'h1)
                    begin
                        line_out <= 1'b1;
                        line_oe  <= 1'b1;
                        state_q  <= SLOTS;
                        slot_q   <= 5'h00;
                        phase_q  <= 2'h0;
                        acc_q    <= 17'h00000;
                    end
                end
                SLOTS:
                begin
                    // Three clocks per slot; sample phase on rising edge
                    line_oe <= 1'b0;
                    phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
                    if (phase_q == 2'h0)
                        acc_q[slot_q] <= ~line_in;
                    if (phase_q == 2'h2)
                    begin
                        if (slot_q == `BIW_SIRQ_SLOTS - 5'h01)
                        begin
                            state_q  <= STOP;
                            cnt_q    <= 4'h0;
                            line_out <= 1'b0;
                            line_oe  <= 1'b1;
                        end
                        else
                            slot_q <= slot_q + 5'h01;
                    end
                end
                STOP:
                begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == `BIW_SIRQ_STOP_CLKS - 4'h1)
                    begin
                        line_out   <= 1'b1;
                        line_oe    <= 1'b0;
                        slot_irq_q <= acc_q;
                        cycle_done <= 1'b1;
                        state_q    <= IDLE;
                    end
                end
                default:
                    state_q <= IDLE;
            endcase
        end
    end
endmodule

// File: test/biw_checker.sv
`timescale 1ns/1ps
module biw_checker (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic [15:0] compat_irq,
    input wire logic        rtc_irq_low,
    input wire logic        pci_other_err,
    input wire logic        power_button_in_n,
    input wire logic        reset_button,
    input wire logic        nmi_button,
    input wire logic [2:0]  sleep_state,
    input wire logic        cpu_intr,
    input wire logic        cpu_nmi,
    input wire logic        serr_out,
    input wire logic        hard_reset,
    input wire logic        wake_event,
    input wire logic        sleep_state3_out,
    input wire logic        serialized_irq_line_out,
    input wire logic        serialized_irq_line_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_off_press;
        $fell(power_button_in_n) && sleep_state == 3'd5;
    endsequence
    sequence s_frame_low;
        (serialized_irq_line_oe && !serialized_irq_line_out) [*2];
    endsequence
    property p_hard_reset;
        reset_button |=> hard_reset;
    endproperty
    a_hard_reset: assert property (p_hard_reset) else $error("hard reset late");
    property p_nmi_button;
        $rose(nmi_button) |-> ##[1:4] cpu_nmi;
    endproperty
    a_nmi_button: assert property (p_nmi_button) else $error("nmi missing");
    property p_serr;
        $rose(pci_other_err) |-> ##[1:4] serr_out;
    endproperty
    a_serr: assert property (p_serr) else $error("serr missing");
    property p_cascade;
        $rose(compat_irq[12]) |-> ##[1:4] cpu_intr;
    endproperty
    a_cascade: assert property (p_cascade) else $error("level 12 lost");
    property p_rtc_low;
        $fell(rtc_irq_low) |-> ##[1:4] cpu_intr;
    endproperty
    a_rtc_low: assert property (p_rtc_low) else $error("rtc level lost");
    property p_wake;
        s_off_press |-> ##[1:4] wake_event;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_supply;
        s_off_press |-> ##[1:4] !sleep_state3_out;
    endproperty
    a_supply: assert property (p_supply) else $error("supply stays off");
    // Start and stop frames both last at least two low clocks
    property p_frame;
        $rose(serialized_irq_line_oe) |-> s_frame_low;
    endproperty
    a_frame: assert property (p_frame) else $error("short frame");
endmodule

bind biw_top biw_checker biw_checker_inst (.*);

// File: test/biw_slave_model.sv
`timescale 1ns/1ps
module biw_slave_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       host_out,
    input  wire logic       host_oe,
    input  wire logic [4:0] slot_sel,
    input  wire logic       start_req,
    output wire logic       line
);
    logic       act_q, low_q;
    logic [2:0] run_q;
    logic [5:0] t_q;
    wire  [6:0] ph = {2'b00, slot_sel} * 7'd3;
    // Pull-up: released wire reads high
    assign line = !((host_oe && !host_out) || low_q);
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            {act_q, low_q, run_q, t_q} <= '0;
        end
        else if (!act_q)
        begin
            run_q <= line ? 3'd0 : run_q + {2'b00, run_q != 3'd7};
            act_q <= line && run_q >= 3'd3;
            t_q   <= 6'd1;
            low_q <= start_req && line;
        end
        else
        begin
            run_q <= 3'd0;
            t_q   <= t_q + 6'd1;
            act_q <= t_q != 6'd50;
            // Low across phase 0 for skew margin
            low_q <= ({1'b0, t_q} + 7'd1 == ph - 7'd1) || ({1'b0, t_q} + 7'd1 == ph);
        end
    end
endmodule

// File: test/board_interrupt_wake_routing_test.sv
`timescale 1ns/1ps
`include "biw_defs.vh"
module board_interrupt_wake_routing_test;
    logic        sys_clk, rst, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, rtc_irq_low, nic_int_a, pci_other_err;
    logic        serialized_irq_line_in, serialized_irq_line_out, serialized_irq_line_oe;
    logic        serr_in, power_button_in_n, reset_button, nmi_button, os_smi_req;
    logic        pme_in, rtc_alarm, mouse_wake, kbd_wake, usb_wake, cpu_intr, cpu_nmi;
    logic        cpu_smi, sci_req, serr_out, hard_reset, wake_event, sleep_state3_out;
    logic        apic_clk, start_req;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
    logic [3:0]  s_axi_wstrb, slot32_int, slot64a_int, slot64b_int;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q, apic_data_in, apic_data_out, apic_data_oe;
    logic [15:0] compat_irq;
    logic [2:0]  sleep_state;
    logic [4:0]  slot_sel;
    int          err_total = 0, checks_done = 0, wake_cnt = 0, n;
    int          pmap[13] = '{18, 21, 22, 20, 23, 16, 17, 18, 19, 21, 22, 23, 20};
    int          wst[10] = '{1, 4, 4, 1, 5, 1, 5, 5, 5, 1};
    int          wsrc[10] = '{1, 1, 2, 3, 0, 0, 4, 0, 0, 1};
    int          wexp[10] = '{1, 1, 0, 1, 0, 1, 1, 0, 1, 0};

    biw_top biw_top_inst (.*);
    biw_slave_model biw_slave_model_inst (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .host_out  (serialized_irq_line_out),
        .host_oe   (serialized_irq_line_oe),
        .slot_sel  (slot_sel),
        .start_req (start_req),
        .line      (serialized_irq_line_in)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Wake pulses are counted, not polled
    always @(posedge sys_clk)
        if (wake_event === 1'b1)
            wake_cnt <= wake_cnt + 1;

    task automatic complete_run;
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic do_rst;
        rst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata  <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        resp_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge sys_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        rd_q = s_axi_rdata;
        resp_q = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(nm, e, rd_q & m);
    endtask

    // Source 0 PME, 1 RTC, 2 mouse, 3 keyboard, 4 power button
    task automatic kick(input int s);
        @(posedge sys_clk);
        {pme_in, rtc_alarm, mouse_wake, kbd_wake} <= {s == 0, s == 1, s == 2, s == 3};
        power_button_in_n <= (s != 4);
        repeat (4) @(posedge sys_clk);
        {pme_in, rtc_alarm, mouse_wake, kbd_wake, power_button_in_n} <= 5'h01;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic sirq_wait(input int b);
        rd_q = '0;
        for (int j = 0; j < 60 && rd_q[b] !== 1'b1; j++)
            rd(`BIW_ADDR_SERIALIZED_IRQ_LINE);
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        complete_run;
    end

    initial
    begin
        clk_en = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, start_req, slot_sel} = '0;
        s_axi_wstrb = 4'hF;
        {compat_irq, nic_int_a, slot32_int, slot64a_int, slot64b_int, sleep_state} = '0;
        {pci_other_err, serr_in, reset_button, nmi_button, os_smi_req, pme_in} = '0;
        {rtc_alarm, mouse_wake, kbd_wake, usb_wake} = '0;
        {rtc_irq_low, power_button_in_n, apic_data_in} = 4'hF;
        do_rst;
        rc("ctrl", `BIW_ADDR_CTRL, 32'hFFFF_FFFF, `BIW_CTRL_RESET);
        rc("wake_en", `BIW_ADDR_WAKE_EN, 32'hFF, 32'h0);
        rd(12'h020);
        chk("rresp", 32'h2, resp_q);
        chk("rdata", 32'h0, rd_q);
        wr(`BIW_ADDR_MSG, 32'h1);
        chk("bresp", 32'h2, resp_q);
        for (int i = 0; i < 13; i++)
        begin
            {slot64b_int, slot64a_int, slot32_int, nic_int_a} <= 13'h1 << i;
            rc("route", `BIW_ADDR_IRQ_STAT, 32'hFF_0000, 32'h1 << pmap[i]);
        end
        {slot64b_int, slot64a_int, slot32_int, nic_int_a} <= 13'h0;
        compat_irq <= 16'h1000;
        rc("intr", `BIW_ADDR_STATUS, 32'h2, 32'h2);
        chk("cpu_intr", 32'h1, cpu_intr);
        compat_irq <= 16'h0;
        rtc_irq_low <= 1'b0;
        rc("rtc", `BIW_ADDR_IRQ_STAT, 32'h100, 32'h100);
        rtc_irq_low <= 1'b1;
        pci_other_err <= 1'b1;
        rc("perr", `BIW_ADDR_PCI_STAT, 32'h1, 32'h1);
        chk("serr", 32'h1, serr_out);
        chk("nmi_off", 32'h0, cpu_nmi);
        wr(`BIW_ADDR_CTRL, 32'h4);
        rd(`BIW_ADDR_STATUS);
        chk("nmi_on", 32'h1, cpu_nmi);
        pci_other_err <= 1'b0;
        wr(`BIW_ADDR_CTRL, 32'h0);
        wr(`BIW_ADDR_PCI_STAT, 32'h1);
        rc("perr_clr", `BIW_ADDR_PCI_STAT, 32'h1, 32'h0);
        chk("nmi_idle", 32'h0, cpu_nmi);
        {nmi_button, reset_button, serr_in} <= 3'h7;
        rd(`BIW_ADDR_STATUS);
        chk("nmi_btn", 32'h1, cpu_nmi);
        chk("hard_rst", 32'h1, hard_reset);
        chk("serr_rpt", 32'h1, serr_out);
        {nmi_button, reset_button, serr_in} <= 3'h0;
        kick(4);
        rc("smi", `BIW_ADDR_STATUS, 32'h5, 32'h4);
        chk("cpu_smi", 32'h1, cpu_smi);
        os_smi_req <= 1'b1;
        rd(`BIW_ADDR_STATUS);
        os_smi_req <= 1'b0;
        wr(`BIW_ADDR_CTRL, 32'h10);
        rc("acpi", `BIW_ADDR_STATUS, 32'h5, 32'h1);
        kick(4);
        rc("sci", `BIW_ADDR_STATUS, 32'hD, 32'h9);
        chk("sci_req", 32'h1, sci_req);
        wr(`BIW_ADDR_WAKE_EN, 32'h7);
        for (int k = 0; k < 10; k++)
        begin
            if (k == 7)
            begin
                chk("sleep3", 32'h0, sleep_state3_out);
                do_rst;
                rc("legacy", `BIW_ADDR_STATUS, 32'h1, 32'h0);
            end
            if (k == 8)
                wr(`BIW_ADDR_WAKE_EN, 32'h1);
            sleep_state <= wst[k][2:0];
            n = wake_cnt;
            kick(wsrc[k]);
            chk("wake", wexp[k], wake_cnt != n);
        end
        slot_sel <= 5'd5;
        sirq_wait(5);
        chk("sirq", 32'h20, rd_q);
        wr(`BIW_ADDR_CTRL, 32'h8);
        slot_sel <= 5'd0;
        repeat (80) @(posedge sys_clk);
        slot_sel <= 5'd7;
        start_req <= 1'b1;
        @(posedge sys_clk);
        start_req <= 1'b0;
        sirq_wait(7);
        chk("sirq_quiet", 32'h80, rd_q);
        complete_run;
    end
endmodule
